/* dowc_assertions.sv */
// dowc_assertions.sv: port-level checks of the output and watchdog block
// assumes: bound to dowc_top, single clock domain sys_clk
`timescale 1ns/1ps

module dowc_assertions
  import dowc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        recov_mode,
  input wire logic        cfg_save,
  input wire logic        mwd_reset,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ----------------
  // bus handshakes
  // ----------------
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
                                 |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata moved");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready too long");
  w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready too long");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");

  // ----------------
  // watchdog, persistence and recovery
  // ----------------
  mwd_width_a: assert property ($rose(mwd_reset) |-> ##15 mwd_reset ##1 !mwd_reset)
    else $error("mwd pulse width");
  save_pulse_a: assert property (cfg_save |=> !cfg_save)
    else $error("save pulse too long");
  recov_fixed_a: assert property ($past(rst_b, 2) |-> $stable(recov_mode))
    else $error("recovery mode moved");
endmodule // dowc_assertions

bind dowc_top dowc_assertions u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .recov_mode(recov_mode), .cfg_save(cfg_save), .mwd_reset(mwd_reset),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* dowc_consts.svh */
// dowc_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by the top module and the testbench, sys_clk at 100 MHz
//
// How it works
// R1: four relay outputs, four inputs, each addressable
// R2: eight bit-rate codes, 1200 up to 115200
// R3: factory address 01, type 40, 9600
// R4: recovery answers address 00, 9600, no checksum
// R5: recovery only from strap sampled at power-up
// R6: rate, checksum, protocol changes only in recovery
// R7: after reset outputs take stored power-on value
// R8: host timeout drives safe value, status 04
// R9: timeout set: output writes ignored, ignore reply
// R10: timeout flag set, saved, cleared by command
// R11: power-on value only when timeout flag clear
// R12: flag clear: write applies value, success reply
// R13: reset-status flag set by reset, read clears
// R14: module watchdog resets logic when kick stops
// R15: low pulses latched between two latch-low reads
// R16: single writes use 00 clear, 01 set
// R17: host watchdog restarts on every addressed command
// R18: latch-low indication clears after report, rearms
`ifndef DOWC_CONSTS_SVH
`define DOWC_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DOWC_OFF_CTRL      12'h000
`define DOWC_OFF_CMD       12'h004
`define DOWC_OFF_STATUS    12'h008
`define DOWC_OFF_OUTVAL    12'h00C
`define DOWC_OFF_PWRON     12'h010
`define DOWC_OFF_SAFE      12'h014
`define DOWC_OFF_HWD_INT   12'h018
`define DOWC_OFF_INPUT     12'h01C
`define DOWC_OFF_LATCH     12'h020
`define DOWC_OFF_CONFIG    12'h024
`define DOWC_OFF_REPLY     12'h028
`define DOWC_OFF_IRQ_STAT  12'h02C
`define DOWC_OFF_IRQ_MASK  12'h030
`define DOWC_OFF_MWD_KICK  12'h034

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define DOWC_CTRL_HWD_EN   0
`define DOWC_CTRL_MWD_EN   1
`define DOWC_ADDR_DEF      8'h01
`define DOWC_ADDR_RECOV    8'h00
`define DOWC_TYPE_DEF      8'h40
`define DOWC_RATE_9600     8'h06
`define DOWC_RATE_MIN      8'h03
`define DOWC_RATE_MAX      8'h0A
`define DOWC_FMT_DEF       8'h00
`define DOWC_FMT_CHK_BIT   6
`define DOWC_STAT_TIMEOUT  8'h04
`define DOWC_STAT_OK       8'h00
`define DOWC_REPLY_OK      8'h3E
`define DOWC_REPLY_IGNORE  8'h21
`define DOWC_REPLY_BAD     8'h3F
`define DOWC_HWD_INT_DEF   32'h0000_0064
`define DOWC_IRQ_TIMEOUT   0
`define DOWC_IRQ_MWD       1
`define DOWC_IRQ_LATCH     2
`define DOWC_IRQ_BAD       3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DOWC_CLK_MHZ       100
`define DOWC_HWD_TICK_US   1000
`define DOWC_HWD_TICK_CYC  (`DOWC_HWD_TICK_US * `DOWC_CLK_MHZ)
`define DOWC_MWD_MS        1000
`define DOWC_MWD_CYC       (`DOWC_MWD_MS * 1000 * `DOWC_CLK_MHZ)
`define DOWC_MWD_PULSE_CYC 16

`endif

/* dowc_field_model.sv */
// dowc_field_model.sv: field-side inputs, idle high, short low pulses
// assumes: pulse_req sampled on sys_clk rising edge
`timescale 1ns/1ps

module dowc_field_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] pulse_req,
  output logic      [3:0] din
);
  // a requested channel goes low one cycle later and stays low while its pulse_req bit is high
  always_ff @(posedge sys_clk)
    din <= ~pulse_req;
endmodule // dowc_field_model

/* dowc_pkg.sv */
// dowc_pkg.sv: types shared by the output and watchdog control block
// assumes: dowc_consts.svh is on the include path
package dowc_pkg;

  // commands issued by the command parser through the register bus
  typedef enum logic [3:0] {
    DOWC_CMD_NONE       = 4'h0,
    DOWC_CMD_STATUS_Q   = 4'h1,
    DOWC_CMD_TO_CLEAR   = 4'h2,
    DOWC_CMD_RST_READ   = 4'h3,
    DOWC_CMD_LATCH_READ = 4'h4,
    DOWC_CMD_INPUT_READ = 4'h5,
    DOWC_CMD_SET_CFG    = 4'h6,
    DOWC_CMD_PROTO_SEL  = 4'h7,
    DOWC_CMD_WRITE_ALL  = 4'h8,
    DOWC_CMD_WRITE_ONE  = 4'h9,
    DOWC_CMD_OTHER      = 4'hA
  } dowc_cmd_e;

  // output source, gray sequence power-on, command, safe
  typedef enum logic [1:0] {
    DOWC_SRC_PWRON = 2'b00,
    DOWC_SRC_CMD   = 2'b01,
    DOWC_SRC_SAFE  = 2'b11
  } dowc_src_e;

  // stored configuration
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] type_code;
    logic [7:0] rate;
    logic [7:0] fmt;
  } dowc_cfg_s;

  // decoded command word
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] chan;
    logic [7:0] addr;
    logic [3:0] pad;
    dowc_cmd_e  op;
  } dowc_cmd_s;

endpackage : dowc_pkg

/* dowc_top.sv */
// dowc_top.sv: output selection, dual watchdog, reset status, input latches
// assumes: AXI4-Lite master on sys_clk, parser writes decoded commands
`timescale 1ns/1ps
`include "dowc_consts.svh"

module dowc_top
  import dowc_pkg::*;
#(
  parameter int unsigned HWD_TICK_CYC = `DOWC_HWD_TICK_CYC,
  parameter int unsigned MWD_CYC      = `DOWC_MWD_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        recov_strap_b,
  input  wire logic [3:0]  din,
  output logic      [3:0]  relay_out,
  output logic             recov_mode,
  output logic             cfg_save,
  output logic             mwd_reset,
  output logic             irq,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // merges a written word into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // true for an offset the map holds
  function automatic logic mapped(input logic [11:0] a);
    return (a <= `DOWC_OFF_MWD_KICK) && (a[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic        strap_seen;
  logic        next_strap_seen, next_recov_mode;
  logic [1:0]  ctrl, next_ctrl;
  logic [3:0]  outval, next_outval, pwron, next_pwron, safe, next_safe;
  logic [31:0] hwd_int, next_hwd_int, hwd_tick, next_hwd_tick;
  logic [31:0] hwd_cnt, next_hwd_cnt, mwd_cnt, next_mwd_cnt;
  logic [4:0]  mwd_pulse, next_mwd_pulse;
  logic        timeout, next_timeout, rst_stat, next_rst_stat;
  logic [3:0]  latch_low, next_latch_low, din_q, next_din_q;
  dowc_cfg_s   cfg, next_cfg;
  dowc_src_e   src, next_src;
  logic [7:0]  reply, next_reply, status, next_status;
  logic [3:0]  irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic        next_cfg_save, next_irq, next_mwd_reset;
  logic [3:0]  next_relay_out;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_go, rd_go, mwd_fire;
  logic [11:0] rd_addr;
  dowc_cmd_s   cmd;

  // write fires once both halves are held and no response waits
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign cmd = dowc_cmd_s'(w_data);
  assign mwd_fire = ctrl[`DOWC_CTRL_MWD_EN] && (mwd_cnt == (MWD_CYC - 1));

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_strap_seen = 1'b1;
    next_recov_mode = strap_seen ? recov_mode : !recov_strap_b; // R5
    next_ctrl       = ctrl;
    next_outval     = outval;
    next_pwron      = pwron;
    next_safe       = safe;
    next_hwd_int    = hwd_int;
    next_timeout    = timeout;
    next_rst_stat   = rst_stat;
    next_cfg        = cfg;
    next_src        = src;
    next_reply      = reply;
    next_status     = timeout ? `DOWC_STAT_TIMEOUT : `DOWC_STAT_OK; // R8
    next_cfg_save   = 1'b0;
    next_irq_mask   = irq_mask;
    next_din_q      = din;
    next_hwd_tick   = hwd_tick;
    next_hwd_cnt    = hwd_cnt;
    next_mwd_cnt    = ctrl[`DOWC_CTRL_MWD_EN] ? mwd_cnt + 32'd1 : 32'd0; // R14
    next_mwd_pulse  = (mwd_pulse != 5'd0) ? mwd_pulse - 5'd1 : 5'd0;
    next_latch_low  = latch_low;
    // bus write channels
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_awready = 1'b0;
    next_wready  = 1'b0;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    if (!aw_held && !s_axi_awready && s_axi_awvalid)
    begin
      next_awready = 1'b1;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (!w_held && !s_axi_wready && s_axi_wvalid)
    begin
      next_wready = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // host watchdog tick prescaler and interval counter
    if (hwd_tick >= HWD_TICK_CYC - 1)
    begin
      next_hwd_tick = 32'd0;
    end
    else
    begin
      next_hwd_tick = hwd_tick + 32'd1;
    end
    if (ctrl[`DOWC_CTRL_HWD_EN] && !timeout && hwd_tick >= HWD_TICK_CYC - 1)
    begin
      if (hwd_cnt + 32'd1 >= hwd_int)
      begin
        next_timeout  = 1'b1; // R10
        next_cfg_save = 1'b1; // R10
        next_src      = DOWC_SRC_SAFE; // R8
        next_hwd_cnt  = 32'd0;
      end
      else
      begin
        next_hwd_cnt = hwd_cnt + 32'd1; // R17
      end
    end
    // register writes and commands
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? 2'b00 : 2'b10;
      if (aw_addr == `DOWC_OFF_CTRL)
      begin
        next_ctrl = 2'(merge({30'd0, ctrl}, w_data, w_strb));
      end
      else if (aw_addr == `DOWC_OFF_PWRON)
      begin
        next_pwron = 4'(merge({28'd0, pwron}, w_data, w_strb));
      end
      else if (aw_addr == `DOWC_OFF_SAFE)
      begin
        next_safe = 4'(merge({28'd0, safe}, w_data, w_strb));
      end
      else if (aw_addr == `DOWC_OFF_HWD_INT)
      begin
        next_hwd_int = merge(hwd_int, w_data, w_strb);
      end
      else if (aw_addr == `DOWC_OFF_IRQ_MASK)
      begin
        next_irq_mask = 4'(merge({28'd0, irq_mask}, w_data, w_strb));
      end
      else if (aw_addr == `DOWC_OFF_MWD_KICK)
      begin
        next_mwd_cnt = 32'd0; // R14
      end
      else if (aw_addr == `DOWC_OFF_CMD)
      begin
        next_reply = `DOWC_REPLY_BAD;
        if (cmd.op != DOWC_CMD_NONE && cmd.addr == (recov_mode ? `DOWC_ADDR_RECOV : cfg.addr))
        begin
          next_hwd_cnt = 32'd0; // R17
          next_reply   = `DOWC_REPLY_OK;
          case (cmd.op)
            DOWC_CMD_TO_CLEAR:
            begin
              next_timeout  = next_timeout && !timeout; // R10
              next_cfg_save = 1'b1;
            end
            DOWC_CMD_RST_READ:
            begin
              next_rst_stat = 1'b0; // R13
              next_reply    = {7'd0, rst_stat};
            end
            DOWC_CMD_LATCH_READ:
            begin
              next_reply     = {4'd0, latch_low}; // R15
              next_latch_low = 4'd0; // R18
            end
            DOWC_CMD_WRITE_ALL, DOWC_CMD_WRITE_ONE:
            begin
              if (timeout)
              begin
                next_reply = `DOWC_REPLY_IGNORE; // R9
              end
              else if (cmd.op == DOWC_CMD_WRITE_ALL)
              begin
                next_outval = cmd.data[3:0]; // R12
                next_src    = DOWC_SRC_CMD;
              end
              else if (cmd.chan < 8'd4 && cmd.data <= 8'h01)
              begin
                next_outval[cmd.chan[1:0]] = cmd.data[0]; // R1 R16
                next_src                   = DOWC_SRC_CMD; // R12
              end
              else
              begin
                next_reply = `DOWC_REPLY_BAD;
              end
            end
            DOWC_CMD_SET_CFG:
            begin
              if (!recov_mode && (cmd.data != cfg.rate)) // R6
              begin
                next_reply = `DOWC_REPLY_BAD;
              end
              else if (cmd.data < `DOWC_RATE_MIN || cmd.data > `DOWC_RATE_MAX) // R2
              begin
                next_reply = `DOWC_REPLY_BAD;
              end
              else
              begin
                next_cfg.addr = cmd.chan;
                next_cfg.rate = cmd.data;
                next_cfg_save = 1'b1;
              end
            end
            DOWC_CMD_PROTO_SEL:
            begin
              next_reply = recov_mode ? `DOWC_REPLY_OK : `DOWC_REPLY_BAD; // R6
            end
            default:
            begin
              next_reply = `DOWC_REPLY_OK;
            end
          endcase
        end
      end
    end
    // timeout set forces safe value
    if (next_timeout)
    begin
      next_src = DOWC_SRC_SAFE; // R8
    end
    else if (src == DOWC_SRC_SAFE && next_src == DOWC_SRC_SAFE)
    begin
      next_src = DOWC_SRC_CMD;
    end
    // latch after clear so a pulse in the read cycle is kept
    next_latch_low = next_latch_low | (din_q & ~din); // R15
    // module watchdog pulse
    if (mwd_fire)
    begin
      next_mwd_pulse = 5'(`DOWC_MWD_PULSE_CYC); // R14
      next_mwd_cnt   = 32'd0;
      next_rst_stat  = 1'b1; // R13
      if (!next_timeout)
      begin
        next_src = DOWC_SRC_PWRON; // R7 R11
      end
    end
    // reads clear the interrupt status
    next_irq_stat = irq_stat;
    if (rd_go && rd_addr == `DOWC_OFF_IRQ_STAT)
    begin
      next_irq_stat = 4'd0;
    end
    next_irq_stat[`DOWC_IRQ_TIMEOUT] |= next_timeout && !timeout;
    next_irq_stat[`DOWC_IRQ_MWD]     |= mwd_fire;
    next_irq_stat[`DOWC_IRQ_LATCH]   |= |(din_q & ~din);
    next_irq_stat[`DOWC_IRQ_BAD]     |= wr_go && aw_addr == `DOWC_OFF_CMD
                                        && next_reply == `DOWC_REPLY_BAD;
    next_irq = |(next_irq_stat & next_irq_mask);
    next_mwd_reset = (next_mwd_pulse != 5'd0);
    // output selection
    case (next_src)
      DOWC_SRC_PWRON: next_relay_out = pwron; // R7 R11
      DOWC_SRC_CMD:   next_relay_out = next_outval;
      default:        next_relay_out = safe; // R8
    endcase
    // read channel
    next_arready = !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(rd_addr) ? 2'b00 : 2'b10;
      next_rdata  = 32'd0;
      if (rd_addr == `DOWC_OFF_CTRL)
        next_rdata = {30'd0, ctrl};
      else if (rd_addr == `DOWC_OFF_STATUS)
        next_rdata = {16'd0, 6'd0, recov_mode, rst_stat, status};
      else if (rd_addr == `DOWC_OFF_OUTVAL)
        next_rdata = {26'd0, src, relay_out};
      else if (rd_addr == `DOWC_OFF_PWRON)
        next_rdata = {28'd0, pwron};
      else if (rd_addr == `DOWC_OFF_SAFE)
        next_rdata = {28'd0, safe};
      else if (rd_addr == `DOWC_OFF_HWD_INT)
        next_rdata = hwd_int;
      else if (rd_addr == `DOWC_OFF_INPUT)
        next_rdata = {28'd0, din_q};
      else if (rd_addr == `DOWC_OFF_LATCH)
        next_rdata = {28'd0, latch_low};
      else if (rd_addr == `DOWC_OFF_CONFIG) // R4
        next_rdata = recov_mode ? {`DOWC_ADDR_RECOV, cfg.type_code, `DOWC_RATE_9600,
                                   cfg.fmt & ~(8'h01 << `DOWC_FMT_CHK_BIT)} : cfg;
      else if (rd_addr == `DOWC_OFF_REPLY)
        next_rdata = {24'd0, reply};
      else if (rd_addr == `DOWC_OFF_IRQ_STAT)
        next_rdata = {28'd0, irq_stat};
      else if (rd_addr == `DOWC_OFF_IRQ_MASK)
        next_rdata = {28'd0, irq_mask};
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_seen <= 1'b0;
      recov_mode <= 1'b0;
      ctrl       <= 2'b00;
      outval     <= 4'h0;
      pwron      <= 4'h0;
      safe       <= 4'h0;
      hwd_int    <= `DOWC_HWD_INT_DEF;
      hwd_tick   <= 32'd0;
      hwd_cnt    <= 32'd0;
      mwd_cnt    <= 32'd0;
      mwd_pulse  <= 5'd0;
      timeout    <= 1'b0;
      rst_stat   <= 1'b1; // R13
      latch_low  <= 4'h0;
      din_q      <= 4'hF;
      cfg        <= {`DOWC_ADDR_DEF, `DOWC_TYPE_DEF, `DOWC_RATE_9600, `DOWC_FMT_DEF}; // R3
      src        <= DOWC_SRC_PWRON; // R7
      reply      <= 8'h00;
      status     <= 8'h00;
      irq_stat   <= 4'h0;
      irq_mask   <= 4'h0;
      relay_out  <= 4'h0;
      cfg_save   <= 1'b0;
      mwd_reset  <= 1'b0;
      irq        <= 1'b0;
      aw_held    <= 1'b0;
      aw_addr    <= 12'h000;
      w_held     <= 1'b0;
      w_data     <= 32'h0000_0000;
      w_strb     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      strap_seen <= next_strap_seen;
      recov_mode <= next_recov_mode;
      ctrl       <= next_ctrl;
      outval     <= next_outval;
      pwron      <= next_pwron;
      safe       <= next_safe;
      hwd_int    <= next_hwd_int;
      hwd_tick   <= next_hwd_tick;
      hwd_cnt    <= next_hwd_cnt;
      mwd_cnt    <= next_mwd_cnt;
      mwd_pulse  <= next_mwd_pulse;
      timeout    <= next_timeout;
      rst_stat   <= next_rst_stat;
      latch_low  <= next_latch_low;
      din_q      <= next_din_q;
      cfg        <= next_cfg;
      src        <= next_src;
      reply      <= next_reply;
      status     <= next_status;
      irq_stat   <= next_irq_stat;
      irq_mask   <= next_irq_mask;
      relay_out  <= next_relay_out;
      cfg_save   <= next_cfg_save;
      mwd_reset  <= next_mwd_reset;
      irq        <= next_irq;
      aw_held    <= next_aw_held;
      aw_addr    <= next_aw_addr;
      w_held     <= next_w_held;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

endmodule // dowc_top

/* tb_dowc_output_watchdog_control.sv */
// tb_dowc_output_watchdog_control.sv: register-level tests of dowc_top
// assumes: short tick of 4 cycles and module watchdog of 200 cycles
`timescale 1ns/1ps
`include "dowc_consts.svh"

module tb_dowc_output_watchdog_control
  import dowc_pkg::*;
;
  logic sys_clk = 0, rst_b = 0, strap_b = 1;
  logic [3:0] pulse_req = 0;
  logic [3:0] din, relay_out;
  logic recov_mode, irq, mwd_reset, cfg_save;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  int n_errors = 0, n_compared = 0, cyc = 0, n_save = 0;

  dowc_top #(.HWD_TICK_CYC(4), .MWD_CYC(200)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .recov_strap_b(strap_b), .din(din), .relay_out(relay_out), .recov_mode(recov_mode),
    .cfg_save(cfg_save), .mwd_reset(mwd_reset), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dowc_field_model u_field (.sys_clk(sys_clk), .pulse_req(pulse_req), .din(din));

  // ----------------
  // clock, timeout, verdict
  // ----------------
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    n_save <= n_save + cfg_save;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------
  // bus tasks
  // ----------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    rs = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  // command word for address 01
  function automatic logic [31:0] cmd(input logic [3:0] op, input logic [7:0] ch,
                                      input logic [7:0] dt);
    return {dt, ch, 8'h01, 4'h0, op};
  endfunction

  task automatic do_reset(input logic strap);
    @(posedge sys_clk);
    rst_b <= 0;
    strap_b <= strap;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1;
    repeat (3) @(posedge sys_clk);
  endtask

  // ----------------
  // tests
  // ----------------
  initial
  begin
    do_reset(1);
    rd(`DOWC_OFF_CONFIG, rv, rs); check("config", rv, 32'h0140_0600);
    rd(`DOWC_OFF_STATUS, rv, rs); check("rst flag", rv[9:8], 2'h1);
    check("relay pwr", relay_out, 4'h0);
    check("recov", recov_mode, 1'b0);
    rd(12'h100, rv, rs); check("unmapped", rs, 2'h2);
    wr(12'h100, 32'h0); check("unmapped wr", rs, 2'h2);
    $display("test reset done");
    wr(`DOWC_OFF_PWRON, 32'h6);
    wr(`DOWC_OFF_SAFE, 32'hA);
    wr(`DOWC_OFF_CMD, cmd(4'h8, 8'h00, 8'h05));
    check("write all", relay_out, 4'h5);
    rd(`DOWC_OFF_REPLY, rv, rs); check("ok reply", rv[7:0], 8'h3E);
    wr(`DOWC_OFF_CMD, cmd(4'h9, 8'h02, 8'h00));
    check("clear one", relay_out, 4'h1);
    wr(`DOWC_OFF_CMD, cmd(4'h9, 8'h03, 8'h01));
    check("set one", relay_out, 4'h9);
    wr(`DOWC_OFF_CMD, cmd(4'h3, 8'h00, 8'h00));
    rd(`DOWC_OFF_STATUS, rv, rs); check("rst clr", rv[8], 1'b0);
    $display("test output done");
    pulse_req <= 4'h2;
    @(posedge sys_clk);
    pulse_req <= 4'h0;
    repeat (3) @(posedge sys_clk);
    rd(`DOWC_OFF_LATCH, rv, rs); check("latched", rv[3:0], 4'h2);
    wr(`DOWC_OFF_CMD, cmd(4'h4, 8'h00, 8'h00));
    rd(`DOWC_OFF_LATCH, rv, rs); check("rearm", rv[3:0], 4'h0);
    $display("test latch done");
    wr(`DOWC_OFF_IRQ_MASK, 32'h1);
    wr(`DOWC_OFF_HWD_INT, 32'h2);
    wr(`DOWC_OFF_CTRL, 32'h1);
    rv = 0;
    for (int i = 0; i < 60 && rv[7:0] !== 8'h04; i++) rd(`DOWC_OFF_STATUS, rv, rs);
    wr(`DOWC_OFF_CTRL, 32'h0);
    check("status", rv[7:0], 8'h04);
    check("safe", relay_out, 4'hA);
    check("irq on", irq, 1'b1);
    rd(`DOWC_OFF_IRQ_STAT, rv, rs); check("irq stat", rv[0], 1'b1);
    rd(`DOWC_OFF_IRQ_STAT, rv, rs); check("irq off", irq, 1'b0);
    wr(`DOWC_OFF_CMD, cmd(4'h8, 8'h00, 8'h03));
    check("ignored", relay_out, 4'hA);
    rd(`DOWC_OFF_REPLY, rv, rs); check("ign reply", rv[7:0], 8'h21);
    wr(`DOWC_OFF_CMD, cmd(4'h2, 8'h00, 8'h00));
    rd(`DOWC_OFF_STATUS, rv, rs); check("to clr", rv[7:0], 8'h00);
    wr(`DOWC_OFF_CMD, cmd(4'h8, 8'h00, 8'h03));
    check("after clr", relay_out, 4'h3);
    check("saves", n_save, 32'h2);
    $display("test host watchdog done");
    wr(`DOWC_OFF_CTRL, 32'h2);
    for (int i = 0; i < 400 && mwd_reset !== 1'b1; i++) @(posedge sys_clk);
    check("mwd fired", mwd_reset, 1'b1);
    repeat (30) @(posedge sys_clk);
    wr(`DOWC_OFF_CTRL, 32'h0);
    check("pwr value", relay_out, 4'h6);
    rd(`DOWC_OFF_STATUS, rv, rs); check("mwd flag", rv[8], 1'b1);
    $display("test module watchdog done");
    wr(`DOWC_OFF_CMD, cmd(4'h6, 8'h01, 8'h08));
    rd(`DOWC_OFF_REPLY, rv, rs); check("cfg refused", rv[7:0], 8'h3F);
    do_reset(0);
    check("recov on", recov_mode, 1'b1);
    rd(`DOWC_OFF_CONFIG, rv, rs); check("recov cfg", rv, 32'h0040_0600);
    $display("test recovery done");
    print_verdict();
  end
endmodule // tb_dowc_output_watchdog_control
